//--- design/cprx_line_sum.sv
/*
 * Per-line ones-complement checksum of the three colour channels, and
 * comparison against the checksum word that follows each line.
 * Assumes the checksum word never arrives in the same cycle as a pixel.
 */
module cprx_line_sum (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic sum_enable_i,
   input wire logic pix_valid_i,
   input wire cprx_pkg::cprx_rgb_t pix_i,
   input wire logic chk_valid_i,
   input wire cprx_pkg::cprx_rgb_t chk_i,
   output logic mismatch_o
);

   logic [2:0][7:0] pix_w;
   logic [2:0][7:0] chk_w;
   logic [2:0] diff_w;
   logic mismatch_r;

   assign pix_w = pix_i;
   assign chk_w = chk_i;

   // ------------------------------------------------------------------
   // per channel accumulators
   // ------------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < 3; ch++) begin : g_chan
         logic [7:0] acc_r;
         logic [8:0] sum_w;
         logic [7:0] acc_nxt;
         assign sum_w = {1'b0, acc_r} + {1'b0, pix_w[ch]};
         // end-around carry
         assign acc_nxt = sum_w[7:0] + {7'h00, sum_w[8]};
         assign diff_w[ch] = (chk_w[ch] != ~acc_r);
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               acc_r <= 8'h00;
            end else if (en_i) begin
               if (!sum_enable_i || chk_valid_i) begin
                  acc_r <= 8'h00;
               end else if (pix_valid_i) begin
                  acc_r <= acc_nxt;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mismatch_r <= 1'b0;
      end else if (en_i) begin
         mismatch_r <= sum_enable_i && chk_valid_i && (|diff_w);
      end
   end

   assign mismatch_o = mismatch_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_line_compare: assert property (
      (en_i && sum_enable_i && chk_valid_i && (chk_w[0] != ~g_chan[0].acc_r))
         |=> mismatch_o)
      else $error("checksum difference not reported");

endmodule

//--- design/cprx_pkg.sv
/*
 * Package of the content-protection receiver register slice: register
 * offsets, field positions, reset values, timing constants and carriers.
 * Assumes a 10 MHz system clock and 8-bit register data.
 */
package cprx_pkg;

   // ------------------------------------------------------------------
   // clock
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_KSV2 = 8'h92;
   localparam logic [7:0] ADDR_KSV3 = 8'h93;
   localparam logic [7:0] ADDR_KSV4 = 8'h94;
   localparam logic [7:0] ADDR_DBG_MIRROR = 8'hc0;
   localparam logic [7:0] ADDR_DBG_LOCAL = 8'hc1;
   localparam logic [7:0] ADDR_STATUS = 8'hc4;

   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int KSV_BYTES = 3;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int DBG_TO_DIS_BIT = 6;
   localparam int DBG_CHKSUM_BIT = 3;
   localparam int DBG_FAST_VERIFY_BIT = 2;
   localparam int DBG_SPEEDUP_BIT = 1;
   localparam int DBG_FAST_BIT = 0;
   localparam logic [7:0] DBG_MIRROR_MASK = 8'h4f;
   localparam int LOCAL_BYPASS_BIT = 1;
   localparam int STATUS_ERR_BIT = 1;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int BUS_TIMEOUT_MS = 1000;
   localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int STD_HALF_BIT_NS = 5000;
   localparam int FAST_HALF_BIT_NS = 1250;
   localparam int STD_HALF_CYC = (STD_HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FAST_HALF_CYC = (FAST_HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int AUTH_TIMER_CYC = 4000;
   localparam int AUTH_SPEEDUP_SHIFT = 4;

   // frame periods of the synchronisation checks
   localparam int SHORT_FAST_FRAMES = 2;
   localparam int LONG_FAST_FRAMES = 16;
   localparam int SHORT_SLOW_FRAMES = 16;
   localparam int LONG_SLOW_FRAMES = 128;
   localparam int FRAME_CNT_W = 7;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } cprx_rgb_t;

   typedef struct packed {
      logic write;
      logic [1:0] index;
      logic [7:0] data;
   } cprx_ksv_upd_t;

endpackage

//--- design/cprx_regs.sv
/*
 * Register slice of the content-protection receiver: transmitter key
 * vector bytes, mirrored debug settings, local debug register, checksum
 * status, and the behaviour those settings steer.
 * Assumes remote updates arrive as one-cycle strobes synchronous to
 * CLK_SYS_I and a register master that never asserts both strobes.
 */
// Behaviour
// - Key vector bytes two to four read back at 0x92..0x94 and reset to zero.
// - The mirrored debug bits are read-only and follow the remote transmitter's writes.
// - With timeout enabled the bus counts as free after one second idle, never when disabled.
// - Line checksums of each 8-bit channel are compared against the word after each line.
// - With fast verification the short check runs every 2 and the long every 16 frames.
// - Without it the short check runs every 16 and the long every 128 frames.
// - The speedup bit shortens the authentication timer.
// - The protection bus master uses fast timing when its bit is set, standard otherwise.
// - The bypass bit routes the still-encrypted data to the RGB outputs, nothing else changes.
// - A checksum mismatch sets a status flag that a write to the status register clears, unless a mismatch comes in the same cycle.
module cprx_regs #(
   parameter int TIMEOUT_CYCLES = cprx_pkg::BUS_TIMEOUT_CYC,
   parameter int TIMEOUT_W = 24,
   parameter int AUTH_CYCLES = cprx_pkg::AUTH_TIMER_CYC,
   parameter int AUTH_W = 16
) (
   input wire logic CLK_SYS_I,
   input wire logic SYS_RST_I,
   input wire logic CLK_EN_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [7:0] REG_RDATA_O,
   input wire cprx_pkg::cprx_ksv_upd_t LINK_KSV_I,
   input wire logic LINK_DBG_WR_I,
   input wire logic [7:0] LINK_DBG_DATA_I,
   input wire logic BUS_ACTIVITY_I,
   output logic BUS_FREE_O,
   output logic BUS_FAST_TIMING_O,
   output logic BUS_HALF_BIT_TICK_O,
   input wire logic FRAME_START_I,
   output logic SHORT_CHECK_O,
   output logic LONG_CHECK_O,
   input wire logic AUTH_TIMER_START_I,
   output logic AUTH_TIMER_DONE_O,
   input wire logic PIX_VALID_I,
   input wire cprx_pkg::cprx_rgb_t PIX_ENC_I,
   input wire cprx_pkg::cprx_rgb_t PIX_DEC_I,
   input wire logic CHK_VALID_I,
   input wire cprx_pkg::cprx_rgb_t CHK_DATA_I,
   output logic RGB_VALID_O,
   output cprx_pkg::cprx_rgb_t RGB_O,
   output logic CHECKSUM_ERROR_O
);

   localparam logic [TIMEOUT_W-1:0] TIMEOUT_LIMIT = TIMEOUT_W'(TIMEOUT_CYCLES);
   localparam logic [AUTH_W-1:0] AUTH_LONG = AUTH_W'(AUTH_CYCLES);
   localparam logic [AUTH_W-1:0] AUTH_SHORT = AUTH_W'(AUTH_CYCLES >> cprx_pkg::AUTH_SPEEDUP_SHIFT);
   localparam logic [5:0] STD_RELOAD = 6'(cprx_pkg::STD_HALF_CYC - 1);
   localparam logic [5:0] FAST_RELOAD = 6'(cprx_pkg::FAST_HALF_CYC - 1);
   localparam int FW = cprx_pkg::FRAME_CNT_W;
   localparam logic [FW-1:0] SHORT_FAST_M = FW'(cprx_pkg::SHORT_FAST_FRAMES - 1);
   localparam logic [FW-1:0] LONG_FAST_M = FW'(cprx_pkg::LONG_FAST_FRAMES - 1);
   localparam logic [FW-1:0] SHORT_SLOW_M = FW'(cprx_pkg::SHORT_SLOW_FRAMES - 1);
   localparam logic [FW-1:0] LONG_SLOW_M = FW'(cprx_pkg::LONG_SLOW_FRAMES - 1);

   logic [cprx_pkg::KSV_BYTES-1:0][7:0] ksv_r;
   logic [7:0] dbg_mirror_r;
   logic [7:0] dbg_local_r;
   logic err_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [TIMEOUT_W-1:0] idle_cnt_r;
   logic bus_free_r;
   logic [5:0] div_cnt_r;
   logic tick_r;
   logic [FW-1:0] frame_cnt_r;
   logic short_r;
   logic long_r;
   logic [AUTH_W-1:0] auth_cnt_r;
   logic auth_run_r;
   logic auth_done_r;
   logic rgb_valid_r;
   cprx_pkg::cprx_rgb_t rgb_r;
   logic mismatch_w;
   logic to_dis_w;
   logic sum_en_w;
   logic fast_verify_w;
   logic speedup_w;
   logic fast_bus_w;
   logic bypass_w;
   logic [FW-1:0] short_mask_w;
   logic [FW-1:0] long_mask_w;

   assign to_dis_w = dbg_mirror_r[cprx_pkg::DBG_TO_DIS_BIT];
   assign sum_en_w = dbg_mirror_r[cprx_pkg::DBG_CHKSUM_BIT];
   assign fast_verify_w = dbg_mirror_r[cprx_pkg::DBG_FAST_VERIFY_BIT];
   assign speedup_w = dbg_mirror_r[cprx_pkg::DBG_SPEEDUP_BIT];
   assign fast_bus_w = dbg_mirror_r[cprx_pkg::DBG_FAST_BIT];
   assign bypass_w = dbg_local_r[cprx_pkg::LOCAL_BYPASS_BIT];

   // ------------------------------------------------------------------
   // key vector bytes, written only from the link
   // ------------------------------------------------------------------
   genvar kb;
   generate
      for (kb = 0; kb < cprx_pkg::KSV_BYTES; kb++) begin : g_ksv
         always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
            if (SYS_RST_I) begin
               ksv_r[kb] <= cprx_pkg::RST_BYTE;
            end else if (CLK_EN_I && LINK_KSV_I.write && (LINK_KSV_I.index == 2'(kb))) begin
               ksv_r[kb] <= LINK_KSV_I.data;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // debug registers
   // ------------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         dbg_mirror_r <= cprx_pkg::RST_BYTE;
      end else if (CLK_EN_I && LINK_DBG_WR_I) begin
         dbg_mirror_r <= LINK_DBG_DATA_I & cprx_pkg::DBG_MIRROR_MASK;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         dbg_local_r <= cprx_pkg::RST_BYTE;
      end else if (CLK_EN_I && REG_WR_I && (REG_ADDR_I == cprx_pkg::ADDR_DBG_LOCAL)) begin
         dbg_local_r <= REG_WDATA_I;
      end
   end

   // ------------------------------------------------------------------
   // checksum status, set wins over clear
   // ------------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         err_r <= 1'b0;
      end else if (CLK_EN_I) begin
         if (mismatch_w) begin
            err_r <= 1'b1;
         end else if (REG_WR_I && (REG_ADDR_I == cprx_pkg::ADDR_STATUS)) begin
            err_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // read port, data one cycle after the strobe
   // ------------------------------------------------------------------
   always_comb begin
      rdata_nxt = 8'h00;
      case (REG_ADDR_I)
         cprx_pkg::ADDR_KSV2: rdata_nxt = ksv_r[0];
         cprx_pkg::ADDR_KSV3: rdata_nxt = ksv_r[1];
         cprx_pkg::ADDR_KSV4: rdata_nxt = ksv_r[2];
         cprx_pkg::ADDR_DBG_MIRROR: rdata_nxt = dbg_mirror_r;
         cprx_pkg::ADDR_DBG_LOCAL: rdata_nxt = dbg_local_r;
         cprx_pkg::ADDR_STATUS: rdata_nxt[cprx_pkg::STATUS_ERR_BIT] = err_r;
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rdata_r <= 8'h00;
      end else if (CLK_EN_I) begin
         rdata_r <= REG_RD_I ? rdata_nxt : 8'h00;
      end
   end

   // ------------------------------------------------------------------
   // bus idle timeout
   // ------------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         idle_cnt_r <= '0;
         bus_free_r <= 1'b0;
      end else if (CLK_EN_I) begin
         if (BUS_ACTIVITY_I) begin
            idle_cnt_r <= '0;
         end else if (idle_cnt_r != TIMEOUT_LIMIT) begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
         end
         bus_free_r <= !to_dis_w && !BUS_ACTIVITY_I && (idle_cnt_r == TIMEOUT_LIMIT);
      end
   end

   // ------------------------------------------------------------------
   // half-bit tick of the protection bus master
   // ------------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         div_cnt_r <= STD_RELOAD;
         tick_r <= 1'b0;
      end else if (CLK_EN_I) begin
         tick_r <= (div_cnt_r == 6'h00);
         if (div_cnt_r == 6'h00) begin
            div_cnt_r <= fast_bus_w ? FAST_RELOAD : STD_RELOAD;
         end else begin
            div_cnt_r <= div_cnt_r - 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // frame based synchronisation checks
   // ------------------------------------------------------------------
   assign short_mask_w = fast_verify_w ? SHORT_FAST_M : SHORT_SLOW_M;
   assign long_mask_w = fast_verify_w ? LONG_FAST_M : LONG_SLOW_M;

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         frame_cnt_r <= '0;
         short_r <= 1'b0;
         long_r <= 1'b0;
      end else if (CLK_EN_I) begin
         short_r <= FRAME_START_I && ((frame_cnt_r & short_mask_w) == '0);
         long_r <= FRAME_START_I && ((frame_cnt_r & long_mask_w) == '0);
         if (FRAME_START_I) begin
            frame_cnt_r <= frame_cnt_r + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // authentication timer
   // ------------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         auth_cnt_r <= '0;
         auth_run_r <= 1'b0;
         auth_done_r <= 1'b0;
      end else if (CLK_EN_I) begin
         auth_done_r <= 1'b0;
         if (AUTH_TIMER_START_I) begin
            auth_cnt_r <= (speedup_w ? AUTH_SHORT : AUTH_LONG) - 1'b1;
            auth_run_r <= 1'b1;
         end else if (auth_run_r) begin
            if (auth_cnt_r == '0) begin
               auth_run_r <= 1'b0;
               auth_done_r <= 1'b1;
            end else begin
               auth_cnt_r <= auth_cnt_r - 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // video output and checksum
   // ------------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rgb_r <= '0;
         rgb_valid_r <= 1'b0;
      end else if (CLK_EN_I) begin
         rgb_valid_r <= PIX_VALID_I;
         if (PIX_VALID_I) begin
            rgb_r <= bypass_w ? PIX_ENC_I : PIX_DEC_I;
         end
      end
   end

   cprx_line_sum u_line_sum (
      .clk_i(CLK_SYS_I),
      .rst_i(SYS_RST_I),
      .en_i(CLK_EN_I),
      .sum_enable_i(sum_en_w),
      .pix_valid_i(PIX_VALID_I),
      .pix_i(PIX_DEC_I),
      .chk_valid_i(CHK_VALID_I),
      .chk_i(CHK_DATA_I),
      .mismatch_o(mismatch_w)
   );

   assign REG_RDATA_O = rdata_r;
   assign BUS_FREE_O = bus_free_r;
   assign BUS_FAST_TIMING_O = fast_bus_w;
   assign BUS_HALF_BIT_TICK_O = tick_r;
   assign SHORT_CHECK_O = short_r;
   assign LONG_CHECK_O = long_r;
   assign AUTH_TIMER_DONE_O = auth_done_r;
   assign RGB_VALID_O = rgb_valid_r;
   assign RGB_O = rgb_r;
   assign CHECKSUM_ERROR_O = err_r;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   logic [AUTH_W-1:0] auth_elapsed_r;
   logic [AUTH_W-1:0] auth_target_r;
   logic [5:0] tick_gap_r;
   logic fast_d_r;
   logic tick_fast_r;

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         auth_elapsed_r <= '0;
         auth_target_r <= '0;
         tick_gap_r <= '0;
         fast_d_r <= 1'b0;
         tick_fast_r <= 1'b0;
      end else if (CLK_EN_I) begin
         if (AUTH_TIMER_START_I) begin
            auth_elapsed_r <= '0;
            auth_target_r <= speedup_w ? AUTH_SHORT : AUTH_LONG;
         end else if (auth_run_r) begin
            auth_elapsed_r <= auth_elapsed_r + 1'b1;
         end
         tick_gap_r <= tick_r ? 6'h01 : tick_gap_r + 1'b1;
         fast_d_r <= fast_bus_w;
         if (tick_r) begin
            tick_fast_r <= fast_d_r;
         end
      end
   end

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SYS_RST_I);

   sequence s_local_write_ro;
      CLK_EN_I && REG_WR_I && !LINK_KSV_I.write && !LINK_DBG_WR_I;
   endsequence

   chk_ksv_read_only: assert property (
      s_local_write_ro |=> ($stable(ksv_r) && $stable(dbg_mirror_r)))
      else $error("local write changed a read-only register");

   chk_mirror_follow: assert property (
      (CLK_EN_I && LINK_DBG_WR_I)
         |=> dbg_mirror_r == ($past(LINK_DBG_DATA_I) & cprx_pkg::DBG_MIRROR_MASK))
      else $error("mirror did not follow remote write");

   chk_ksv_readback: assert property (
      (CLK_EN_I && REG_RD_I && (REG_ADDR_I == cprx_pkg::ADDR_KSV3))
         |=> REG_RDATA_O == $past(ksv_r[1]))
      else $error("key byte three read back wrong");

   chk_timeout_off: assert property (
      to_dis_w |=> !BUS_FREE_O || !$past(CLK_EN_I))
      else $error("bus free while timeout disabled");

   chk_timeout_on: assert property (
      (CLK_EN_I && !to_dis_w && !BUS_ACTIVITY_I && idle_cnt_r == TIMEOUT_LIMIT) |=> BUS_FREE_O)
      else $error("bus not free after idle timeout");

   chk_short_period: assert property (
      (CLK_EN_I && FRAME_START_I)
         |=> SHORT_CHECK_O == (($past(frame_cnt_r)
            & ($past(fast_verify_w) ? SHORT_FAST_M : SHORT_SLOW_M)) == '0))
      else $error("short check at wrong frame");

   chk_long_period: assert property (
      (CLK_EN_I && FRAME_START_I)
         |=> LONG_CHECK_O == (($past(frame_cnt_r)
            & ($past(fast_verify_w) ? LONG_FAST_M : LONG_SLOW_M)) == '0))
      else $error("long check at wrong frame");

   chk_auth_length: assert property (
      AUTH_TIMER_DONE_O |-> auth_elapsed_r == auth_target_r)
      else $error("authentication timer length wrong");

   chk_auth_speed: assert property (
      (CLK_EN_I && AUTH_TIMER_START_I)
         |=> auth_target_r == ($past(speedup_w) ? AUTH_SHORT : AUTH_LONG))
      else $error("timer speedup not applied");

   chk_tick_spacing: assert property (
      (CLK_EN_I && tick_r) |-> tick_gap_r == (tick_fast_r ? 6'(cprx_pkg::FAST_HALF_CYC)
                                                        : 6'(cprx_pkg::STD_HALF_CYC)))
      else $error("half-bit tick spacing wrong");

   chk_bypass_data: assert property (
      (CLK_EN_I && PIX_VALID_I)
         |=> RGB_VALID_O && RGB_O == ($past(bypass_w) ? $past(PIX_ENC_I) : $past(PIX_DEC_I)))
      else $error("video output source wrong");

   chk_err_set: assert property (
      (CLK_EN_I && mismatch_w) |=> CHECKSUM_ERROR_O)
      else $error("checksum flag not set");

   chk_err_clear: assert property (
      (CLK_EN_I && !mismatch_w && REG_WR_I && REG_ADDR_I == cprx_pkg::ADDR_STATUS)
         |=> !CHECKSUM_ERROR_O)
      else $error("checksum flag not cleared by write");

   chk_read_gap: assert property (
      (CLK_EN_I && !REG_RD_I) |=> REG_RDATA_O == 8'h00)
      else $error("read data outside read slot");

endmodule

//--- testbench/content_protect_rx_debug_regs_tb.sv
/* Self-checking bench of the receiver register slice.
   Assumes cprx_regs with shortened timeout and authentication counts. */
`define CK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
   $display("BAD %0t got %h exp %h", $time, a, e); end end
module content_protect_rx_debug_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, en, wr, rd, act, fs, ast;
   logic [7:0] addr, wdat, rdat, dbg;
   logic free, fast, tick, shrt, lng, adone, rgbv, err, dwr, pv, cv;
   cprx_pkg::cprx_rgb_t rgb, enc, dec, chk;
   cprx_pkg::cprx_ksv_upd_t ksv;
   int fails = 0, cmp_count = 0, ns = 0, nl = 0, nv = 0, n;
   logic [7:0] regs [6] = '{8'h92, 8'h93, 8'h94, 8'hc0, 8'hc1, 8'hc4};
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) if (shrt === 1'b1) ns++;
   always @(posedge clk) if (lng === 1'b1) nl++;
   always @(posedge clk) if (rgbv === 1'b1) nv++;
   cprx_tx_model tx (.clk_i(clk), .ksv_o(ksv), .dbg_wr_o(dwr), .dbg_o(dbg), .pv_o(pv),
      .enc_o(enc), .dec_o(dec), .cv_o(cv), .chk_o(chk));
   cprx_regs #(.TIMEOUT_CYCLES(20), .AUTH_CYCLES(64)) DUT (.CLK_SYS_I(clk), .SYS_RST_I(rst),
      .CLK_EN_I(en), .REG_ADDR_I(addr), .REG_WDATA_I(wdat), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_RDATA_O(rdat), .LINK_KSV_I(ksv), .LINK_DBG_WR_I(dwr), .LINK_DBG_DATA_I(dbg),
      .BUS_ACTIVITY_I(act), .BUS_FREE_O(free), .BUS_FAST_TIMING_O(fast),
      .BUS_HALF_BIT_TICK_O(tick), .FRAME_START_I(fs), .SHORT_CHECK_O(shrt),
      .LONG_CHECK_O(lng), .AUTH_TIMER_START_I(ast), .AUTH_TIMER_DONE_O(adone),
      .PIX_VALID_I(pv), .PIX_ENC_I(enc), .PIX_DEC_I(dec), .CHK_VALID_I(cv),
      .CHK_DATA_I(chk), .RGB_VALID_O(rgbv), .RGB_O(rgb), .CHECKSUM_ERROR_O(err));
   task cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rreg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdat;
   endtask
   task frames(input int k);
      repeat (k) begin
         @(posedge clk) fs <= 1'b1;
         @(posedge clk) fs <= 1'b0;
      end
      cyc(3);
   endtask
   task auth(output int c);
      @(posedge clk) ast <= 1'b1;
      @(posedge clk) ast <= 1'b0;
      c = 0;
      while (adone !== 1'b1 && c < 200) begin
         cyc(1);
         c++;
      end
   endtask
   task period(output int p);
      p = 0;
      while (tick !== 1'b1 && p < 100) begin
         cyc(1);
         p++;
      end
      p = 0;
      do begin
         cyc(1);
         p++;
      end while (tick !== 1'b1 && p < 100);
   endtask
   task finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      finish_test();
   end
   initial begin
      logic [7:0] v;
      rst = 1'b1;
      en = 1'b1;
      {wr, rd, act, fs, ast} = 5'h00;
      addr = 8'h00;
      wdat = 8'h00;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rreg(regs[i], v);
         `CK(v, 8'h00)
      end
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         tx.set_key(2'(i), 8'(8'h3c + i));
         wreg(8'(8'h92 + i), 8'hff);
         rreg(8'(8'h92 + i), v);
         `CK(v, 8'(8'h3c + i))
      end
      tx.set_dbg(8'hff);
      wreg(8'hc0, 8'h00);
      rreg(8'hc0, v);
      `CK(v, 8'h4f)
      $display("test read-only done");
      tx.send_line(3, 1'b0);
      cyc(3);
      `CK(err, 1'b0)
      tx.send_line(3, 1'b1);
      cyc(3);
      `CK(err, 1'b1)
      rreg(8'hc4, v);
      `CK(v, 8'h02)
      wreg(8'hc4, 8'h00);
      cyc(2);
      `CK(err, 1'b0)
      wreg(8'hc1, 8'ha6);
      rreg(8'hc1, v);
      `CK(v, 8'ha6)
      tx.send_line(1, 1'b0);
      cyc(2);
      `CK(rgb, ~tx.px(0))
      `CK(err, 1'b0)
      wreg(8'hc1, 8'h00);
      tx.send_line(1, 1'b0);
      cyc(2);
      `CK(rgb, tx.px(0))
      `CK(nv, 8)
      $display("test checksum and bypass done");
      tx.set_dbg(8'h00);
      @(posedge clk) act <= 1'b1;
      @(posedge clk) act <= 1'b0;
      cyc(20);
      `CK(free, 1'b0)
      cyc(1);
      `CK(free, 1'b1)
      tx.set_dbg(8'h40);
      cyc(30);
      `CK(free, 1'b0)
      $display("test timeout done");
      tx.set_dbg(8'h00);
      ns = 0;
      nl = 0;
      frames(128);
      `CK(ns, 8)
      `CK(nl, 1)
      tx.set_dbg(8'h04);
      ns = 0;
      nl = 0;
      frames(16);
      `CK(ns, 8)
      `CK(nl, 1)
      $display("test frames done");
      auth(n);
      `CK(n, 64)
      tx.set_dbg(8'h02);
      auth(n);
      `CK(n, 4)
      $display("test timer done");
      tx.set_dbg(8'h00);
      cyc(1);
      `CK(fast, 1'b0)
      period(n);
      `CK(n, 50)
      tx.set_dbg(8'h01);
      cyc(1);
      `CK(fast, 1'b1)
      period(n);
      `CK(n, 13)
      $display("test bus timing done");
      @(posedge clk) en <= 1'b0;
      wreg(8'hc1, 8'h5a);
      tx.set_key(2'd0, 8'h99);
      @(posedge clk) en <= 1'b1;
      rreg(8'hc1, v);
      `CK(v, 8'h00)
      rreg(8'h92, v);
      `CK(v, 8'h3c)
      $display("test freeze done");
      finish_test();
   end
endmodule

//--- testbench/cprx_tx_model.sv
/* Remote transmitter model: key byte updates, debug settings, video lines.
   Assumes the receiver samples every input on the rising edge of clk_i. */
module cprx_tx_model (
   input wire logic clk_i,
   output cprx_pkg::cprx_ksv_upd_t ksv_o,
   output logic dbg_wr_o,
   output logic [7:0] dbg_o,
   output logic pv_o,
   output cprx_pkg::cprx_rgb_t enc_o,
   output cprx_pkg::cprx_rgb_t dec_o,
   output logic cv_o,
   output cprx_pkg::cprx_rgb_t chk_o
);
   timeunit 1ns;
   timeprecision 1ns;
   cprx_pkg::cprx_rgb_t acc;
   initial begin
      ksv_o = '0;
      dbg_wr_o = 1'b0;
      dbg_o = 8'h00;
      pv_o = 1'b0;
      enc_o = '0;
      dec_o = '0;
      cv_o = 1'b0;
      chk_o = '0;
   end
   function automatic cprx_pkg::cprx_rgb_t px(input int i);
      return 24'(24'h908070 + 24'h151515 * i);
   endfunction
   function automatic logic [7:0] oc(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + 8'(s[8]);
   endfunction
   task set_dbg(input logic [7:0] d);
      @(posedge clk_i);
      dbg_o <= d;
      dbg_wr_o <= 1'b1;
      @(posedge clk_i);
      dbg_wr_o <= 1'b0;
      dbg_o <= ~d;
   endtask
   task set_key(input logic [1:0] i, input logic [7:0] d);
      @(posedge clk_i);
      ksv_o <= '{1'b1, i, d};
      @(posedge clk_i);
      ksv_o <= '{1'b0, ~i, ~d};
   endtask
   // bad sends the raw sum instead of its complement
   task send_line(input int n, input logic bad);
      cprx_pkg::cprx_rgb_t p;
      acc = '0;
      for (int i = 0; i < n; i++) begin
         p = px(i);
         @(posedge clk_i);
         pv_o <= 1'b1;
         dec_o <= p;
         enc_o <= ~p;
         acc = {oc(acc.red, p.red), oc(acc.green, p.green), oc(acc.blue, p.blue)};
      end
      @(posedge clk_i);
      pv_o <= 1'b0;
      dec_o <= ~dec_o;
      enc_o <= ~enc_o;
      cv_o <= 1'b1;
      chk_o <= bad ? acc : ~acc;
      @(posedge clk_i);
      cv_o <= 1'b0;
      chk_o <= ~chk_o;
   endtask
endmodule
